// File: design/fopg_guard.sv
// Fast overcurrent guard: debounced trip, PWM blanking, constant current
// and secondary overcurrent flags, with a Wishbone register file.
// Assumes a one-cycle cycle_start_i pulse from the PWM generator.
//
// Functional notes
// - Debounce code selects 0, 40, 80, 120 ns.
// - Trip needs unbroken high for debounce time.
// - Trip blanks all PWM for cycle remainder.
// - Balance bit adds modulation on legs B, D.
// - Bypass bit takes trip from external flag.
// - Constant current mode 10% below secondary limit.
// - Secondary flag when value exceeds limit; max 254.
// - PWM resumes at next switching cycle start.
//
// Implementation choice: register access over Wishbone.
module fopg_guard (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire fopg_pkg::fopg_wb_req_t wb_req_i,
    output fopg_pkg::fopg_wb_rsp_t wb_rsp_o,
    // Sense inputs
    input wire logic primary_current_sense_i,
    input wire logic external_flag_input_i,
    input wire logic [7:0] secondary_current_value_i,
    // PWM generator side
    input wire logic cycle_start_i,
    input wire logic [fopg_pkg::NUM_PWM-1:0] pwm_i,
    input wire logic [1:0] vs_trim_i,
    // Outputs
    output logic [fopg_pkg::NUM_PWM-1:0] pwm_o,
    output logic fast_blank_o,
    output logic secondary_ocp_o,
    output logic cc_active_o,
    output logic irq_o
);

    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        logic [7:0] fast_set;
        logic [7:0] sec_limit;
        logic [7:0] sec_val;
        logic [fopg_pkg::NUM_EV-1:0] status;
        logic [fopg_pkg::NUM_EV-1:0] mask;
        logic qual_prev;
        logic cc_prev;
        logic blank;
        logic [fopg_pkg::NUM_PWM-1:0] pwm;
        logic sec_ocp;
        logic cc_active;
        logic irq;
    } fopg_guard_state_t;

    localparam fopg_guard_state_t STATE_RST = '{
        ack: 1'b0,
        rdat: 32'h0000_0000,
        fast_set: fopg_pkg::FAST_SET_RST,
        sec_limit: fopg_pkg::SEC_LIMIT_RST,
        sec_val: 8'h00,
        status: 3'h0,
        mask: fopg_pkg::IRQ_MASK_RST,
        qual_prev: 1'b0,
        cc_prev: 1'b0,
        blank: 1'b0,
        pwm: 4'h0,
        sec_ocp: 1'b0,
        cc_active: 1'b0,
        irq: 1'b0
    };

    fopg_guard_state_t q, d;

    logic [1:0] pins_s;
    logic primary_s;
    logic ext_flag_s;
    logic src_level;
    logic qual;

    // Pin synchronisers
    fopg_sync #(.W(2)) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i({external_flag_input_i, primary_current_sense_i}),
        .sync_o(pins_s)
    );

    assign primary_s = pins_s[0];
    assign ext_flag_s = pins_s[1];

    // Trip source select
    assign src_level = q.fast_set[fopg_pkg::BYP_BIT] ? ext_flag_s : primary_s;

    // Debounce qualifier
    fopg_debounce u_deb (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .level_i(src_level),
        .sel_i(q.fast_set[fopg_pkg::DEB_HI:fopg_pkg::DEB_LO]),
        .qual_o(qual)
    );

    logic req;
    logic wr;
    logic [9:0] idx;
    logic [11:0] cc_thr;
    logic sec_over;
    logic cc_on;
    logic [fopg_pkg::NUM_EV-1:0] ev;
    logic [fopg_pkg::NUM_EV-1:0] w1c;
    logic [fopg_pkg::NUM_PWM-1:0] shaped;

    // Next state of the whole block
    always_comb begin
        d = q;
        req = wb_req_i.cyc & wb_req_i.stb & ~q.ack;
        wr = req & wb_req_i.we & wb_req_i.sel[0];
        idx = wb_req_i.adr[11:2];
        w1c = '0;

        // Bus answer, one cycle after the request
        d.ack = req;
        d.rdat = 32'h0000_0000;
        if (req && !wb_req_i.we) begin
            case (idx)
                fopg_pkg::IDX_SEC_VALUE: d.rdat = {24'h000000, q.sec_val};
                fopg_pkg::IDX_SEC_LIMIT: d.rdat = {24'h000000, q.sec_limit};
                fopg_pkg::IDX_FAST_SET: d.rdat = {24'h000000, q.fast_set};
                fopg_pkg::IDX_IRQ_STATUS: d.rdat = {29'h0000000, q.status};
                fopg_pkg::IDX_IRQ_MASK: d.rdat = {29'h0000000, q.mask};
                default: d.rdat = 32'h0000_0000;
            endcase
        end

        // Register writes
        if (wr) begin
            case (idx)
                fopg_pkg::IDX_SEC_LIMIT: begin
                    // Forbidden 255 is held at the maximum
                    if (wb_req_i.dat[7:0] > fopg_pkg::SEC_LIMIT_MAX) begin
                        d.sec_limit = fopg_pkg::SEC_LIMIT_MAX;
                    end else begin
                        d.sec_limit = wb_req_i.dat[7:0];
                    end
                end
                fopg_pkg::IDX_FAST_SET: d.fast_set = wb_req_i.dat[7:0];
                fopg_pkg::IDX_IRQ_STATUS: w1c = wb_req_i.dat[fopg_pkg::NUM_EV-1:0];
                fopg_pkg::IDX_IRQ_MASK: d.mask = wb_req_i.dat[fopg_pkg::NUM_EV-1:0];
                default: d.mask = q.mask;
            endcase
        end

        // Secondary comparisons
        d.sec_val = secondary_current_value_i;
        sec_over = q.sec_val > q.sec_limit;
        cc_thr = (12'(q.sec_limit) * fopg_pkg::CC_NUM) / fopg_pkg::CC_DEN;
        cc_on = q.fast_set[fopg_pkg::CCM_BIT] && (12'(q.sec_val) > cc_thr);
        d.sec_ocp = sec_over;
        d.cc_active = cc_on;
        d.cc_prev = cc_on;
        d.qual_prev = qual;

        // Blanking: trip wins over a cycle start in the same clock
        if (qual) begin
            d.blank = 1'b1;
        end else if (cycle_start_i) begin
            d.blank = 1'b0;
        end

        // Balance modulation trims legs B and D
        shaped = pwm_i;
        if (q.fast_set[fopg_pkg::VSB_BIT]) begin
            shaped[fopg_pkg::LEG_B] = pwm_i[fopg_pkg::LEG_B] & ~vs_trim_i[0];
            shaped[fopg_pkg::LEG_D] = pwm_i[fopg_pkg::LEG_D] & ~vs_trim_i[1];
        end
        d.pwm = d.blank ? '0 : shaped;

        // Sticky events, set wins over clear
        ev = '0;
        ev[fopg_pkg::EV_FAST] = qual & ~q.qual_prev;
        ev[fopg_pkg::EV_SEC] = sec_over;
        ev[fopg_pkg::EV_CC] = cc_on & ~q.cc_prev;
        d.status = (q.status & ~w1c) | ev;
        d.irq = |(d.status & d.mask);
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= STATE_RST;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from flops
    assign wb_rsp_o = '{ack: q.ack, dat: q.rdat};
    assign pwm_o = q.pwm;
    assign fast_blank_o = q.blank;
    assign secondary_ocp_o = q.sec_ocp;
    assign cc_active_o = q.cc_active;
    assign irq_o = q.irq;

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_blank_pwm_off: assert property (q.blank |-> pwm_o == '0)
        else $error("PWM active while blanked");
    a_trip_blanks: assert property (qual |=> q.blank && pwm_o == '0)
        else $error("qualified trip did not blank PWM");
    a_resume_next: assert property (q.blank && cycle_start_i && !qual |=> !q.blank)
        else $error("PWM did not resume at cycle start");
    a_blank_holds: assert property (q.blank && !cycle_start_i |=> q.blank)
        else $error("blanking ended mid cycle");
    a_bypass_source: assert property (q.fast_set[fopg_pkg::BYP_BIT] && !ext_flag_s
        |-> src_level == 1'b0)
        else $error("bypass did not select external flag");
    a_vsb_off_pass: assert property (!q.blank && !$past(q.fast_set[fopg_pkg::VSB_BIT])
        && !$past(q.blank) |-> pwm_o == $past(pwm_i))
        else $error("PWM altered with balance off");
    a_vsb_trims: assert property (q.fast_set[fopg_pkg::VSB_BIT] && vs_trim_i[0] && !qual
        && !q.blank |=> !pwm_o[fopg_pkg::LEG_B])
        else $error("leg B not trimmed by balance");
    a_cc_off: assert property (!q.fast_set[fopg_pkg::CCM_BIT] |=> !cc_active_o)
        else $error("constant current active while disabled");
    a_sec_flag: assert property (q.sec_val > q.sec_limit
        |=> secondary_ocp_o && q.status[fopg_pkg::EV_SEC])
        else $error("secondary overcurrent flag missing");
    a_limit_cap: assert property (q.sec_limit <= fopg_pkg::SEC_LIMIT_MAX)
        else $error("secondary limit above maximum");
    a_wb_ack_pulse: assert property (wb_req_i.cyc && wb_req_i.stb && !q.ack
        |=> q.ack ##1 !q.ack)
        else $error("bus ack not a single-cycle answer");

    c_fast_trip: cover property ($rose(q.blank));
    c_resume: cover property (q.blank ##1 !q.blank);
    c_bypass_trip: cover property (q.fast_set[fopg_pkg::BYP_BIT] && $rose(qual));
    c_cc_engage: cover property ($rose(cc_active_o));
    c_irq: cover property ($rose(irq_o));

endmodule

// File: design/fopg_pkg.sv
// Constants, field layout and carrier types of the fast overcurrent guard.
// Assumes a 200 MHz core clock and a classic Wishbone register bus.
package fopg_pkg;

    // Clock and debounce timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int TICK_NS = 40;
    localparam int TICK_CYC = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] TICK_LAST = 3'(TICK_CYC - 1);

    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_SEC_VALUE = 10'h018;
    localparam logic [9:0] IDX_SEC_LIMIT = 10'h026;
    localparam logic [9:0] IDX_FAST_SET = 10'h027;
    localparam logic [9:0] IDX_IRQ_STATUS = 10'h040;
    localparam logic [9:0] IDX_IRQ_MASK = 10'h041;

    // Reset values
    localparam logic [7:0] FAST_SET_RST = 8'h00;
    localparam logic [7:0] SEC_LIMIT_RST = 8'hFE;
    localparam logic [7:0] SEC_LIMIT_MAX = 8'hFE;
    localparam logic [2:0] IRQ_MASK_RST = 3'h0;

    // Field positions of the fast overcurrent setting
    localparam int DEB_HI = 7;
    localparam int DEB_LO = 6;
    localparam int VSB_BIT = 5;
    localparam int BYP_BIT = 4;
    localparam int CCM_BIT = 3;

    // Event bits of status and mask
    localparam int EV_FAST = 0;
    localparam int EV_SEC = 1;
    localparam int EV_CC = 2;
    localparam int NUM_EV = 3;

    // Constant current level as a fraction of the secondary limit
    localparam logic [11:0] CC_NUM = 12'h009;
    localparam logic [11:0] CC_DEN = 12'h00A;

    // PWM legs
    localparam int NUM_PWM = 4;
    localparam int LEG_B = 1;
    localparam int LEG_D = 3;

    // Wishbone request and response
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [11:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } fopg_wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } fopg_wb_rsp_t;

    // Debounce qualifier states
    typedef enum logic [1:0] {
        DEB_IDLE = 2'b00,
        DEB_COUNT = 2'b01,
        DEB_QUAL = 2'b11
    } fopg_deb_state_t;

endpackage

// File: design/fopg_sync.sv
// Three-stage synchroniser for asynchronous pins.
// Assumes inputs change slowly against the 200 MHz clock.
module fopg_sync #(
    parameter int W = 2
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Pins and result
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] out;
    } fopg_sync_state_t;

    fopg_sync_state_t q, d;
    logic [W-1:0] agree;

    // Output follows only when stages two and three agree
    for (genvar i = 0; i < W; i++) begin : g_bit
        assign agree[i] = (q.s2[i] == q.s3[i]) ? q.s3[i] : q.out[i];
    end

    // Shift chain
    always_comb begin
        d = q;
        d.s1 = async_i;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.out = agree;
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign sync_o = q.out;

endmodule

// File: design/fopg_debounce.sv
// Debounce qualifier for the selected fast overcurrent source.
// Assumes a synchronised level input and a stable select code.
module fopg_debounce (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Source level and debounce code
    input wire logic level_i,
    input wire logic [1:0] sel_i,
    // Qualified trip level
    output logic qual_o
);

    typedef struct packed {
        fopg_pkg::fopg_deb_state_t st;
        logic [2:0] pre;
        logic [1:0] ticks;
    } fopg_deb_q_t;

    fopg_deb_q_t q, d;
    logic [7:0] run_q;

    // Count 40 ns ticks of unbroken high level
    always_comb begin
        d = q;
        if (!level_i) begin
            d = '{st: fopg_pkg::DEB_IDLE, pre: 3'h0, ticks: 2'h0};
        end else begin
            case (q.st)
                fopg_pkg::DEB_IDLE: begin
                    d.st = (sel_i == 2'h0) ? fopg_pkg::DEB_QUAL : fopg_pkg::DEB_COUNT;
                end
                fopg_pkg::DEB_COUNT: begin
                    d.pre = q.pre + 3'h1;
                    if (q.pre == fopg_pkg::TICK_LAST) begin
                        d.pre = 3'h0;
                        d.ticks = q.ticks + 2'h1;
                        if (q.ticks + 2'h1 == sel_i) begin
                            d.st = fopg_pkg::DEB_QUAL;
                        end
                    end
                end
                fopg_pkg::DEB_QUAL: d.st = fopg_pkg::DEB_QUAL;
                default: d.st = fopg_pkg::DEB_IDLE;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '{st: fopg_pkg::DEB_IDLE, pre: 3'h0, ticks: 2'h0};
        end else begin
            q <= d;
        end
    end

    assign qual_o = (q.st == fopg_pkg::DEB_QUAL);

    // Helper: run length of the high level
    always_ff @(posedge clk_i) begin
        if (rst_i || !level_i) begin
            run_q <= 8'h00;
        end else if (run_q != 8'hFF) begin
            run_q <= run_q + 8'h01;
        end
    end

    a_deb_min_time: assert property (@(posedge clk_i) disable iff (rst_i)
        qual_o |-> run_q >= 8'({6'h00, sel_i} * 8'(fopg_pkg::TICK_CYC)))
        else $error("trip qualified before debounce time");
    a_deb_drop_reset: assert property (@(posedge clk_i) disable iff (rst_i)
        !level_i |=> q.st == fopg_pkg::DEB_IDLE && q.ticks == 2'h0)
        else $error("debounce count not cleared on low level");

endmodule

// File: verif/fopg_stage_model.sv
// Power stage model: switching cycles, raw legs and fault comparators.
// Assumes one clock; the bench commands each fault pulse.
module fopg_stage_model #(
    parameter int PER = 64
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Fault command
    input wire logic fire_i,
    input wire logic ext_i,
    input wire logic [7:0] len_i,
    // Stage side
    output logic cycle_start_o,
    output logic [3:0] pwm_o,
    output logic primary_current_sense_o,
    output logic external_flag_input_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    int left = 0;
    logic ext_q = 1'b0;
    logic cs_q = 1'b0;
    logic [3:0] pwm_q = 4'h0;
    // Cycle counter, random legs and pulse length
    always @(posedge clk_i) begin
        cnt <= (rst_i || cnt == PER - 1) ? 0 : cnt + 1;
        cs_q <= !rst_i && cnt == PER - 1;
        pwm_q <= rst_i ? 4'h0 : 4'($urandom);
        if (fire_i) begin
            left <= len_i;
            ext_q <= ext_i;
        end else if (left != 0) begin
            left <= left - 1;
        end
    end
    // Comparators idle low outside a fault
    assign cycle_start_o = cs_q;
    assign pwm_o = pwm_q;
    assign primary_current_sense_o = left != 0 && !ext_q;
    assign external_flag_input_o = left != 0 && ext_q;
endmodule

// File: verif/tb_top.sv
// Self-checking bench of the fast overcurrent guard.
// Assumes the stage model drives sense pins, legs and cycle starts.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    fopg_pkg::fopg_wb_req_t req = '0;
    fopg_pkg::fopg_wb_rsp_t rsp;
    logic cs, pcs, efl, blank, socp, cca, irq;
    logic fire = 1'b0;
    logic ext = 1'b0;
    logic [7:0] len = 8'h00;
    logic [7:0] sval = 8'h00;
    logic [7:0] set_m = 8'h00;
    logic [1:0] trim = 2'h0;
    logic [3:0] praw, pout;
    logic [3:0] pexp = 4'h0;
    logic [31:0] rd;
    int fail_count = 0;
    int total_checks = 0;
    int cyc_n = 0;
    int lim, v;

    // Clock
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end

    fopg_guard dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp),
        .primary_current_sense_i(pcs), .external_flag_input_i(efl), .secondary_current_value_i(sval),
        .cycle_start_i(cs), .pwm_i(praw), .vs_trim_i(trim), .pwm_o(pout), .fast_blank_o(blank),
        .secondary_ocp_o(socp), .cc_active_o(cca), .irq_o(irq));
    fopg_stage_model stage_u (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire), .ext_i(ext), .len_i(len),
        .cycle_start_o(cs), .pwm_o(praw), .primary_current_sense_o(pcs), .external_flag_input_o(efl));

    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        total_checks++;
        if (seen !== want) begin
            fail_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Classic single cycle; waits for ack, then idles one cycle
    task automatic wb(input logic w, input logic [9:0] idx, input logic [7:0] d);
        req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: {idx, 2'b00}, sel: 4'h1, dat: {24'h0, d}};
        if (w && idx == fopg_pkg::IDX_FAST_SET) set_m <= d;
        do @(posedge clk_i); while (rsp.ack !== 1'b1);
        rd = rsp.dat;
        req <= '0;
        @(posedge clk_i);
    endtask

    task automatic rdchk(input logic [9:0] idx, input logic [31:0] want);
        wb(1'b0, idx, 8'h00);
        chk(rd, want);
    endtask

    // Fault pulse at a cycle start; watch blanking and its release
    task automatic pulse(input logic e, input int l, input logic trip);
        int n;
        n = 0;
        do @(posedge clk_i); while (cs !== 1'b1);
        fire <= 1'b1;
        ext <= e;
        len <= l[7:0];
        @(posedge clk_i);
        fire <= 1'b0;
        repeat (44) begin
            @(posedge clk_i);
            n += (blank === 1'b1);
        end
        chk(n != 0, trip);
        if (trip) begin
            do @(posedge clk_i); while (cs !== 1'b1);
            chk(blank, 1'b1);
            repeat (2) @(posedge clk_i);
            chk(blank, 1'b0);
        end
        wb(1'b0, fopg_pkg::IDX_IRQ_STATUS, 8'h00);
        chk(rd[0], trip);
        wb(1'b1, fopg_pkg::IDX_IRQ_STATUS, 8'h01);
    endtask

    // Leg reference: blanked legs low, else last raw legs with cuts
    always @(posedge clk_i) begin
        if (!rst_i && !req.cyc && !rsp.ack) chk(pout, blank === 1'b1 ? 4'h0 : pexp);
        pexp <= set_m[5] ? praw & ~{trim[1], 1'b0, trim[0], 1'b0} : praw;
    end

    // Cycle ceiling and random balance cut requests
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        trim <= 2'($urandom);
        if (cyc_n == 20000) begin
            fail_count++;
            print_verdict();
        end
    end

    // Main sequence
    initial begin
        void'($urandom(32'hA213));
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rdchk(fopg_pkg::IDX_FAST_SET, 32'h0);
        rdchk(fopg_pkg::IDX_SEC_LIMIT, 32'hFE);
        rdchk(fopg_pkg::IDX_IRQ_MASK, 32'h0);
        rdchk(fopg_pkg::IDX_IRQ_STATUS, 32'h0);
        rdchk(10'h3FF, 32'h0);
        v = $urandom;
        wb(1'b1, fopg_pkg::IDX_FAST_SET, v[7:0]);
        rdchk(fopg_pkg::IDX_FAST_SET, {24'h0, v[7:0]});
        wb(1'b1, fopg_pkg::IDX_SEC_LIMIT, 8'hFF);
        rdchk(fopg_pkg::IDX_SEC_LIMIT, 32'hFE);
        // Each debounce code past its time; codes 1 to 3 first just short of it
        for (int c = 0; c < 4; c++) begin
            wb(1'b1, fopg_pkg::IDX_FAST_SET, {c[1:0], 6'h00});
            if (c != 0) pulse(1'b0, 8 * c - 1, 1'b0);
            pulse(1'b0, 8 * c + 4, 1'b1);
        end
        // Trip source follows the bypass bit
        wb(1'b1, fopg_pkg::IDX_FAST_SET, 8'h10);
        pulse(1'b0, 20, 1'b0);
        pulse(1'b1, 20, 1'b1);
        wb(1'b1, fopg_pkg::IDX_FAST_SET, 8'h00);
        pulse(1'b1, 20, 1'b0);
        // Balance cuts, judged by the leg reference
        wb(1'b1, fopg_pkg::IDX_FAST_SET, 8'h20);
        repeat (200) @(posedge clk_i);
        // Secondary flag and constant current near their thresholds
        for (int i = 0; i < 8; i++) begin
            lim = $urandom_range(254, 20);
            v = (i[0] ? lim * 9 / 10 : lim) + $urandom_range(2) - 1;
            wb(1'b1, fopg_pkg::IDX_FAST_SET, i[2] ? 8'h00 : 8'h08);
            wb(1'b1, fopg_pkg::IDX_SEC_LIMIT, lim[7:0]);
            sval <= v[7:0];
            repeat (4) @(posedge clk_i);
            chk(socp, v > lim);
            chk(cca, set_m[3] && v > lim * 9 / 10);
            rdchk(fopg_pkg::IDX_SEC_VALUE, {24'h0, v[7:0]});
        end
        // Interrupt raised, cleared, then masked
        sval <= 8'hFF;
        wb(1'b1, fopg_pkg::IDX_IRQ_MASK, 8'h02);
        repeat (3) @(posedge clk_i);
        chk(irq, 1'b1);
        sval <= 8'h00;
        repeat (3) @(posedge clk_i);
        wb(1'b1, fopg_pkg::IDX_IRQ_STATUS, 8'h07);
        rdchk(fopg_pkg::IDX_IRQ_STATUS, 32'h0);
        chk(irq, 1'b0);
        sval <= 8'hFF;
        wb(1'b1, fopg_pkg::IDX_IRQ_MASK, 8'h01);
        repeat (3) @(posedge clk_i);
        chk(irq, 1'b0);
        rdchk(fopg_pkg::IDX_IRQ_STATUS, 32'h2);
        print_verdict();
    end
endmodule
